// file: src/bsc_commutation.sv
// Six-step commutation core: sensor or sensorless position, gate drive, speed.
// Expects pwm_chop, sensorless_mode and A/D samples from logic on clk_sys; sensor, direction and stop pins are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module bsc_commutation (
    // Clock, reset, enable
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire logic                       clk_en,
    // Position sensor pins
    input  wire logic                       position_sensor_u_input,
    input  wire logic                       position_sensor_v_input,
    input  wire logic                       position_sensor_w_input,
    // Mode and protection pins
    input  wire logic                       clockwise_direction,
    input  wire logic                       overcurrent_stop_input_n,
    input  wire logic                       sensorless_mode,
    // Carrier and converted phase voltages
    input  wire logic                       pwm_chop,
    input  wire logic                       adc_valid,
    input  wire logic [bsc_pkg::ADC_W-1:0]  adc_u,
    input  wire logic [bsc_pkg::ADC_W-1:0]  adc_v,
    input  wire logic [bsc_pkg::ADC_W-1:0]  adc_w,
    // Gate drive
    output logic                            gate_u_hi,
    output logic                            gate_v_hi,
    output logic                            gate_w_hi,
    output logic                            gate_u_lo,
    output logic                            gate_v_lo,
    output logic                            gate_w_lo,
    // Status
    output logic [2:0]                      position_code,
    output logic [bsc_pkg::TMR_W-1:0]       speed_period,
    output logic                            speed_valid,
    output logic                            sensor_error
);
    import bsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [SY_BITS-1:0] sync1_ff;
    logic [SY_BITS-1:0] sync2_ff;
    logic [SY_BITS-1:0] nxt_sync1;
    logic [SY_BITS-1:0] nxt_sync2;

    always_comb begin
        nxt_sync1 = sync1_ff;
        nxt_sync2 = sync2_ff;
        if (clk_en) begin
            nxt_sync1 = {overcurrent_stop_input_n, clockwise_direction,
                         position_sensor_w_input, position_sensor_v_input,
                         position_sensor_u_input};
            nxt_sync2 = sync1_ff;
        end
    end

    // Idle as stop asserted so gates stay off until the pin is seen
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    logic [2:0] hall_code;
    logic       oc_active;
    logic       dir_cw;
    assign hall_code = sync2_ff[SY_W:SY_U];
    assign oc_active = !sync2_ff[SY_OC_N];
    assign dir_cw    = sync2_ff[SY_CW];

    ////////////////////////////////////////////////////////////////////////////
    // Position, timing and gate state
    logic [TMR_W-1:0] timer_ff, nxt_timer;
    logic [TMR_W-1:0] caps_ff [NUM_SECTORS];
    logic [TMR_W-1:0] nxt_caps [NUM_SECTORS];
    logic [2:0]       cap_idx_ff, nxt_cap_idx;
    logic [2:0]       cap_cnt_ff, nxt_cap_cnt;
    logic [TMR_W-1:0] period_ff, nxt_period;
    logic             spd_ok_ff, nxt_spd_ok;
    logic [2:0]       code_ff, nxt_code;
    logic [2:0]       cmp_ff, nxt_cmp;
    logic [2:0]       filt_ff, nxt_filt;
    logic [1:0]       fcnt_ff, nxt_fcnt;
    logic [TMR_W-1:0] zc_time_ff, nxt_zc_time;
    logic [TMR_W-1:0] dly_ff, nxt_dly;
    logic             dly_run_ff, nxt_dly_run;
    logic [2:0]       pend_ff, nxt_pend;
    logic [5:0]       gate_ff, nxt_gate;
    logic             err_ff, nxt_err;
    logic             event_c;
    logic             zc_c;
    logic [SUM_W-1:0] sum_c;
    logic [2:0]       raw_c;
    logic [TMR_W-1:0] intv_c;

    always_comb begin
        nxt_timer   = timer_ff;
        nxt_caps    = caps_ff;
        nxt_cap_idx = cap_idx_ff;
        nxt_cap_cnt = cap_cnt_ff;
        nxt_period  = period_ff;
        nxt_spd_ok  = spd_ok_ff;
        nxt_code    = code_ff;
        nxt_cmp     = cmp_ff;
        nxt_filt    = filt_ff;
        nxt_fcnt    = fcnt_ff;
        nxt_zc_time = zc_time_ff;
        nxt_dly     = dly_ff;
        nxt_dly_run = dly_run_ff;
        nxt_pend    = pend_ff;
        nxt_gate    = gate_ff;
        nxt_err     = err_ff;
        event_c     = 1'b0;
        zc_c        = 1'b0;
        intv_c      = timer_ff - zc_time_ff;
        // Compare 3*phase with the phase sum to avoid a divider
        sum_c = {2'h0, adc_u} + {2'h0, adc_v} + {2'h0, adc_w};
        raw_c[0] = (({2'h0, adc_u} << 1) + {2'h0, adc_u}) > sum_c;
        raw_c[1] = (({2'h0, adc_v} << 1) + {2'h0, adc_v}) > sum_c;
        raw_c[2] = (({2'h0, adc_w} << 1) + {2'h0, adc_w}) > sum_c;
        if (clk_en) begin
            nxt_timer = timer_ff + 32'h1;
            if (!sensorless_mode) begin
                nxt_dly_run = 1'b0;
                if (hall_code != code_ff) begin
                    nxt_code = hall_code;
                    event_c  = 1'b1;
                end
            end else begin
                if (adc_valid) begin
                    // A pattern must repeat before it counts as settled
                    nxt_cmp = raw_c;
                    if (raw_c != cmp_ff) begin
                        nxt_fcnt = 2'h0;
                    end else if (fcnt_ff < FILT_SAMPLES - 2'h1) begin
                        nxt_fcnt = fcnt_ff + 2'h1;
                    end else if (raw_c != filt_ff) begin
                        nxt_filt    = raw_c;
                        zc_c        = 1'b1;
                        nxt_zc_time = timer_ff;
                        nxt_dly     = intv_c >> 1;
                        nxt_dly_run = 1'b1;
                        nxt_pend    = raw_c;
                    end
                end
                // A crossing restarts the delay so a stale pattern is never applied
                if (dly_run_ff && !zc_c) begin
                    if (dly_ff == 32'h0) begin
                        nxt_dly_run = 1'b0;
                        if (pend_ff != code_ff) begin
                            nxt_code = pend_ff;
                            event_c  = 1'b1;
                        end
                    end else begin
                        nxt_dly = dly_ff - 32'h1;
                    end
                end
            end
            if (event_c) begin
                nxt_caps[cap_idx_ff] = timer_ff;
                nxt_period = timer_ff - caps_ff[cap_idx_ff];
                nxt_spd_ok = (cap_cnt_ff == FULL_CNT);
                if (cap_cnt_ff != FULL_CNT) begin
                    nxt_cap_cnt = cap_cnt_ff + 3'h1;
                end
                nxt_cap_idx = (cap_idx_ff == LAST_IDX) ? 3'h0 : cap_idx_ff + 3'h1;
            end
            nxt_err = !bsc_code_valid(code_ff);
            if (oc_active || !bsc_code_valid(code_ff)) begin
                nxt_gate = 6'h00;
            end else begin
                nxt_gate = bsc_pattern(code_ff, dir_cw, pwm_chop);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timer_ff   <= '0;
            caps_ff    <= '{default: '0};
            cap_idx_ff <= 3'h0;
            cap_cnt_ff <= 3'h0;
            period_ff  <= '0;
            spd_ok_ff  <= 1'b0;
            code_ff    <= CODE_ALL0;
            cmp_ff     <= 3'h0;
            filt_ff    <= 3'h0;
            fcnt_ff    <= 2'h0;
            zc_time_ff <= '0;
            dly_ff     <= '0;
            dly_run_ff <= 1'b0;
            pend_ff    <= 3'h0;
            gate_ff    <= 6'h00;
            err_ff     <= 1'b0;
        end else begin
            timer_ff   <= nxt_timer;
            caps_ff    <= nxt_caps;
            cap_idx_ff <= nxt_cap_idx;
            cap_cnt_ff <= nxt_cap_cnt;
            period_ff  <= nxt_period;
            spd_ok_ff  <= nxt_spd_ok;
            code_ff    <= nxt_code;
            cmp_ff     <= nxt_cmp;
            filt_ff    <= nxt_filt;
            fcnt_ff    <= nxt_fcnt;
            zc_time_ff <= nxt_zc_time;
            dly_ff     <= nxt_dly;
            dly_run_ff <= nxt_dly_run;
            pend_ff    <= nxt_pend;
            gate_ff    <= nxt_gate;
            err_ff     <= nxt_err;
        end
    end

    assign {gate_w_hi, gate_v_hi, gate_u_hi} = gate_ff[5:3];
    assign {gate_w_lo, gate_v_lo, gate_u_lo} = gate_ff[2:0];
    assign position_code = code_ff;
    assign speed_period  = period_ff;
    assign speed_valid   = spd_ok_ff;
    assign sensor_error  = err_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_hall_follow;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !sensorless_mode && hall_code != code_ff |=> code_ff == $past(hall_code);
    endproperty
    a_hall_follow: assert property (p_hall_follow) else $error("code missed sensor edge");

    property p_sector_step;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && event_c |=> cap_idx_ff == (($past(cap_idx_ff) == LAST_IDX) ? 3'h0
                                             : $past(cap_idx_ff) + 3'h1);
    endproperty
    a_sector_step: assert property (p_sector_step) else $error("sector index bad");

    property p_one_switch_per_arm;
        @(posedge clk_sys) disable iff (!reset_n)
        $onehot0(gate_ff[5:3]) && $onehot0(gate_ff[2:0]) && (gate_ff[5:3] & gate_ff[2:0]) == 3'h0;
    endproperty
    a_one_switch_per_arm: assert property (p_one_switch_per_arm) else $error("gate overlap");

    // Chopping removes the upper switch, so only unchopped cycles are counted
    property p_two_phases;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && sensorless_mode && pwm_chop && !oc_active && bsc_code_valid(code_ff)
        |=> $countones(gate_ff) == 2;
    endproperty
    a_two_phases: assert property (p_two_phases) else $error("not two phases");

    property p_timer_run;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> timer_ff == $past(timer_ff) + 32'h1;
    endproperty
    a_timer_run: assert property (p_timer_run) else $error("timer not free running");

    property p_speed_diff;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && event_c |=> period_ff == $past(timer_ff) - $past(caps_ff[cap_idx_ff]);
    endproperty
    a_speed_diff: assert property (p_speed_diff) else $error("speed difference wrong");

    property p_half_delay;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && zc_c |=> dly_ff == ($past(intv_c) >> 1) && dly_run_ff;
    endproperty
    a_half_delay: assert property (p_half_delay) else $error("delay not half interval");

    property p_delay_commit;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && sensorless_mode && dly_run_ff && !zc_c && dly_ff == 32'h0
        |=> code_ff == $past(pend_ff) && !dly_run_ff;
    endproperty
    a_delay_commit: assert property (p_delay_commit) else $error("pseudo code not applied");

    property p_freeze;
        @(posedge clk_sys) disable iff (!reset_n)
        !clk_en |=> timer_ff == $past(timer_ff) && code_ff == $past(code_ff)
                    && gate_ff == $past(gate_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_oc_stop;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && oc_active |=> gate_ff == 6'h00;
    endproperty
    a_oc_stop: assert property (p_oc_stop) else $error("gates on during stop");

    property p_bad_code;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en && !bsc_code_valid(code_ff) |=> gate_ff == 6'h00 && err_ff;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("invalid code not blocked");

    c_hall_event: cover property (@(posedge clk_sys) !sensorless_mode && event_c);
    c_zc_commit: cover property (@(posedge clk_sys) sensorless_mode && event_c);
    c_speed_ok: cover property (@(posedge clk_sys) $rose(spd_ok_ff));
    c_oc_trip: cover property (@(posedge clk_sys) oc_active && gate_ff == 6'h00);
endmodule : bsc_commutation
`default_nettype wire

// file: src/bsc_pkg.sv
// Constants and shared decode for the six-step commutation block.
// Assumes one 100 MHz system clock; A/D samples arrive already converted.
////////////////////////////////////////////////////////////////////////////////
package bsc_pkg;
    localparam int          TMR_W        = 32;
    localparam int          ADC_W        = 12;
    localparam int          SUM_W        = ADC_W + 2;
    localparam int          NUM_SECTORS  = 6;
    localparam int          SECTOR_DEG   = 60;
    localparam int          CONDUCT_DEG  = 120;
    localparam logic [2:0]  LAST_IDX     = 3'h5;
    localparam logic [2:0]  FULL_CNT     = 3'h6;
    localparam logic [2:0]  CODE_ALL0    = 3'h0;
    localparam logic [2:0]  CODE_ALL1    = 3'h7;
    localparam logic [1:0]  FILT_SAMPLES = 2'h2;
    // Sync vector layout
    localparam int          SY_U         = 0;
    localparam int          SY_W         = 2;
    localparam int          SY_CW        = 3;
    localparam int          SY_OC_N      = 4;
    localparam int          SY_BITS      = 5;
    // Stop pin reads as asserted until synchronised, so gates start off
    localparam logic [SY_BITS-1:0] SYNC_RST = 5'h08;

    function automatic logic bsc_code_valid(input logic [2:0] code);
        return (code != CODE_ALL0) && (code != CODE_ALL1);
    endfunction : bsc_code_valid

    // Returns {hi[w,v,u], lo[w,v,u]}; reverse direction swaps the arms
    function automatic logic [5:0] bsc_pattern(input logic [2:0] code,
                                               input logic       cw,
                                               input logic       chop);
        logic [2:0] hi;
        logic [2:0] lo;
        hi = 3'h0;
        lo = 3'h0;
        unique case (code)
            3'h5: begin hi = 3'h1; lo = 3'h2; end
            3'h4: begin hi = 3'h1; lo = 3'h4; end
            3'h6: begin hi = 3'h2; lo = 3'h4; end
            3'h2: begin hi = 3'h2; lo = 3'h1; end
            3'h3: begin hi = 3'h4; lo = 3'h1; end
            3'h1: begin hi = 3'h4; lo = 3'h2; end
            default: begin hi = 3'h0; lo = 3'h0; end
        endcase
        if (!cw) begin
            return {lo & {3{chop}}, hi};
        end
        return {hi & {3{chop}}, lo};
    endfunction : bsc_pattern
endpackage : bsc_pkg

// file: test/bsc_bridge_model.sv
// Inverter bridge and motor seen from the gate pins: phase voltages after conversion.
// Assumes the bench chooses the back-EMF sign pattern; samples are taken on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module bsc_bridge_model (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    // Gate drive from the block
    input  wire logic [5:0]                 gates,
    // Back-EMF sign pattern wanted by the bench, {w,v,u}
    input  wire logic [2:0]                 emf_pattern,
    // Converted phase voltages
    output logic [bsc_pkg::ADC_W-1:0]       adc_u,
    output logic [bsc_pkg::ADC_W-1:0]       adc_v,
    output logic [bsc_pkg::ADC_W-1:0]       adc_w,
    // Sticky flag: an upper and lower switch of one leg were on together
    output logic                            shoot_ff
);
    import bsc_pkg::*;
    logic nxt_shoot;
    // Levels chosen so three times a high phase beats the sum, a low one does not
    assign adc_u = emf_pattern[0] ? 12'hbb8 : 12'h3e8;
    assign adc_v = emf_pattern[1] ? 12'hbb8 : 12'h3e8;
    assign adc_w = emf_pattern[2] ? 12'hbb8 : 12'h3e8;
    // A real bridge shorts the supply here, so it is never forgiven
    always_comb begin
        nxt_shoot = shoot_ff | (|(gates[5:3] & gates[2:0]));
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shoot_ff <= 1'b0;
        end else begin
            shoot_ff <= nxt_shoot;
        end
    end
endmodule : bsc_bridge_model
`default_nettype wire

// file: test/bsc_commutation_tb.sv
// Self-checking bench for the commutation core: sensor drive, faults, sensorless drive.
// Assumes the bridge model beside it; clk_en drops only in the freeze scenario.
`timescale 1ns/1ps
`default_nettype none
module bsc_commutation_tb;
    import bsc_pkg::*;
    logic             clk_sys   = 1'b0;
    logic             reset_n   = 1'b0;
    logic [2:0]       hall      = 3'h0;
    logic             cw        = 1'b1;
    logic             oc_n      = 1'b1;
    logic             en        = 1'b1;
    logic             sl        = 1'b0;
    logic             chop      = 1'b1;
    logic             adc_valid = 1'b0;
    logic [2:0]       emf       = 3'h0;
    logic [ADC_W-1:0] adc_u, adc_v, adc_w;
    wire logic [5:0]  gates;
    logic [2:0]       position_code;
    logic [TMR_W-1:0] speed_period;
    logic             speed_valid, sensor_error, shoot;
    logic [2:0]       seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    int               err_count   = 0;
    int               comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    bsc_commutation DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(en),
        .position_sensor_u_input(hall[0]), .position_sensor_v_input(hall[1]),
        .position_sensor_w_input(hall[2]), .clockwise_direction(cw),
        .overcurrent_stop_input_n(oc_n), .sensorless_mode(sl), .pwm_chop(chop),
        .adc_valid(adc_valid), .adc_u(adc_u), .adc_v(adc_v), .adc_w(adc_w),
        .gate_u_hi(gates[3]), .gate_v_hi(gates[4]), .gate_w_hi(gates[5]),
        .gate_u_lo(gates[0]), .gate_v_lo(gates[1]), .gate_w_lo(gates[2]),
        .position_code(position_code), .speed_period(speed_period),
        .speed_valid(speed_valid), .sensor_error(sensor_error));

    bsc_bridge_model bridge (.clk_sys(clk_sys), .reset_n(reset_n), .gates(gates),
        .emf_pattern(emf), .adc_u(adc_u), .adc_v(adc_v), .adc_w(adc_w), .shoot_ff(shoot));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] expected,
                         input string what);
        comparisons++;
        if (seen !== expected) begin
            err_count++;
            $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, expected);
        end
    endtask : check

    // Gate word {hi w,v,u, lo w,v,u}; reversal swaps arms, chopping gates the upper arm
    function automatic logic [5:0] exp_gates(input logic [2:0] code, input logic dir,
                                             input logic ch);
        logic [5:0] hl;
        case (code)
            3'h5: hl = 6'h0a;
            3'h4: hl = 6'h0c;
            3'h6: hl = 6'h14;
            3'h2: hl = 6'h11;
            3'h3: hl = 6'h21;
            3'h1: hl = 6'h22;
            default: hl = 6'h00;
        endcase
        if (!dir) begin
            hl = {hl[2:0], hl[5:3]};
        end
        return {hl[5:3] & {3{ch}}, hl[2:0]};
    endfunction : exp_gates

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    ////////////////////////////////////////////////////////////////////////////
    task automatic sensor_spin();
        int on_cnt;
        on_cnt = 0;
        for (int i = 0; i < 12; i++) begin
            // Uneven sectors 16/20/24: a revolution still spans 120 cycles
            @(posedge clk_sys) hall <= seq[i % 6];
            cyc(15 + 4 * (i % 3));
            check(position_code, seq[i % 6], "sensor code");
            check(gates, exp_gates(seq[i % 6], 1'b1, 1'b1), "sensor gates");
            on_cnt += gates[3];
        end
        check(on_cnt, 2 * CONDUCT_DEG / SECTOR_DEG, "upper u sectors");
        check(speed_period, 120, "sensor speed");
        check(speed_valid, 1'b1, "speed valid");
    endtask : sensor_spin

    task automatic reverse_and_chop();
        @(posedge clk_sys) cw <= 1'b0;
        cyc(6);
        check(gates, exp_gates(3'h1, 1'b0, 1'b1), "reverse gates");
        chop <= 1'b0;
        cyc(3);
        check(gates, exp_gates(3'h1, 1'b0, 1'b0), "chopped gates");
        chop <= 1'b1;
        cw   <= 1'b1;
        cyc(6);
    endtask : reverse_and_chop

    task automatic invalid_codes();
        for (int i = 0; i < 2; i++) begin
            hall <= i ? CODE_ALL1 : CODE_ALL0;
            cyc(6);
            check(gates, 0, "invalid gates");
            check(sensor_error, 1'b1, "invalid flag");
            hall <= 3'h5;
            cyc(6);
            check(sensor_error, 1'b0, "valid again");
        end
    endtask : invalid_codes

    task automatic overcurrent();
        oc_n <= 1'b0;
        cyc(4);
        check(gates, 0, "stop gates");
        oc_n <= 1'b1;
        cyc(6);
        check(gates, exp_gates(3'h5, 1'b1, 1'b1), "after stop");
    endtask : overcurrent

    task automatic freeze();
        en   <= 1'b0;
        hall <= 3'h4;
        cyc(6);
        check(position_code, 3'h5, "frozen code");
        check(gates, exp_gates(3'h5, 1'b1, 1'b1), "frozen gates");
        en <= 1'b1;
        cyc(6);
        check(position_code, 3'h4, "thawed code");
        hall <= 3'h5;
        cyc(6);
    endtask : freeze

    ////////////////////////////////////////////////////////////////////////////
    task automatic sample(input logic [2:0] p);
        @(posedge clk_sys) emf <= p;
        adc_valid <= 1'b1;
        @(posedge clk_sys) adc_valid <= 1'b0;
        cyc(8);
    endtask : sample

    // Six samples per step, 60 cycles; one lone deviant sample sits inside late steps
    task automatic sensorless();
        sl <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            for (int s = 0; s < 6; s++) begin
                sample((i >= 8 && s == 3) ? ~seq[i % 6] : seq[i % 6]);
                if (i >= 8 && s == 2) begin
                    check(position_code, seq[(i + 5) % 6], "held by delay");
                end
            end
            if (i >= 8) begin
                check(position_code, seq[i % 6], "pseudo code");
                check(gates, exp_gates(seq[i % 6], 1'b1, 1'b1), "two phases");
            end
        end
        check(speed_period, 360, "sensorless speed");
        check(shoot, 1'b0, "leg short");
    endtask : sensorless

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // Whole run is about 1160 cycles; this limit is about seventeen times that
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end

    initial begin
        cyc(6);
        reset_n <= 1'b1;
        cyc(2);
        check(sensor_error, 1'b1, "reset code");
        sensor_spin();
        reverse_and_chop();
        invalid_codes();
        overcurrent();
        freeze();
        sensorless();
        give_verdict();
    end
endmodule : bsc_commutation_tb
`default_nettype wire
